// File: design/ipa_pkg.sv
package ipa_pkg;

   // level select codes seen on the two address bits during acknowledge
   localparam logic [1:0] SEL_VIDEO  = 2'h3;
   localparam logic [1:0] SEL_LEVEL5 = 2'h2;
   localparam logic [1:0] SEL_TIMER  = 2'h1;

   // width of the pin synchroniser bank
   localparam int unsigned SYNC_W = 8;

   // all request, acknowledge and response lines idle high
   localparam logic LINE_IDLE = 1'b1;

   typedef enum logic [8:0] {
      ST_IDLE    = 9'h001,
      ST_TIM_ACK = 9'h002,
      ST_TIM_VPA = 9'h004,
      ST_VID_ACK = 9'h008,
      ST_VID_VPA = 9'h010,
      ST_SER_ACK = 9'h020,
      ST_SER_DTK = 9'h040,
      ST_PIF_ACK = 9'h080,
      ST_PIF_VPA = 9'h100
   } ipa_state_e;

   typedef struct packed {
      logic iack;
      logic level_sel_hi;
      logic level_sel_lo;
      logic data_strobe_n;
      logic video_req_n;
      logic serial_req_n;
      logic pif_req_n;
      logic timer_req_n;
   } ipa_pins_s;

   typedef struct packed {
      logic timer_ack_n;
      logic video_ack_n;
      logic serial_ack_n;
      logic pif_ack_n;
      logic vpa_n;
      logic dtack_n;
   } ipa_resp_s;

   localparam ipa_resp_s RESP_IDLE = '{default: LINE_IDLE};

endpackage : ipa_pkg

// File: design/ipa_sync.sv
`timescale 1ns/100ps
module ipa_sync
   import ipa_pkg::*;
(
   input  wire logic              sys_clk_i,
   input  wire logic              rstn_i,
   input  wire logic [SYNC_W-1:0] async_i,
   output logic      [SYNC_W-1:0] sync_o
);

   logic [SYNC_W-1:0] stage1;

   // two flops per pin; stage1 feeds only stage two
   genvar b;
   generate
      for (b = 0; b < SYNC_W; b++) begin : g_bit
         always_ff @(posedge sys_clk_i or negedge rstn_i) begin
            if (!rstn_i) begin
               stage1[b] <= LINE_IDLE;
               sync_o[b] <= LINE_IDLE;
            end else begin
               stage1[b] <= async_i[b];
               sync_o[b] <= stage1[b];
            end
         end
      end
   endgenerate

endmodule : ipa_sync

// File: design/ipa_seq_top.sv
`timescale 1ns/100ps
// Operation
// R1: level-2 line low for video, serial, peripheral
// R2: level-1 line low for video or lone timer
// R3: video level 7, serial/peripheral 5, timer 2
// R4: active-low request in, separate acknowledge out
// R5: acknowledge cycle needs iack high, strobe low
// R6: timer, peripheral, video answer with autovector
// R7: serial answered with transfer acknowledge
// R8: serial acknowledge first, transfer acknowledge after
// R9: peripheral acknowledged only if serial idle
// R10: hold acknowledge state while cycle persists
// R11: video acknowledge marks its two states
// R12: one registered output changes per step; both priority level lines can change in one step
// R13: outputs registered, all high in idle
module ipa_seq_top
   import ipa_pkg::*;
(
   input  wire logic sys_clk_i,
   input  wire logic rstn_i,
   input  wire logic iack_i,
   input  wire logic level_sel_hi_i,
   input  wire logic level_sel_lo_i,
   input  wire logic data_strobe_n_i,
   input  wire logic video_req_n_i,
   input  wire logic serial_req_n_i,
   input  wire logic pif_req_n_i,
   input  wire logic timer_req_n_i,
   output logic      prio_level_bit1_n_o,
   output logic      prio_level_bit2_n_o,
   output logic      timer_ack_n_o,
   output logic      video_ack_n_o,
   output logic      serial_ack_n_o,
   output logic      pif_ack_n_o,
   output logic      vpa_n_o,
   output logic      dtack_n_o
);

   ipa_pins_s  pins;
   ipa_pins_s  sr;
   ipa_state_e state;
   ipa_state_e next_state;
   ipa_resp_s  resp;
   logic       cycle_on;
   logic       vid_cyc;
   logic       lvl5_cyc;
   logic       tim_cyc;
   logic [1:0] sel;

   // R4: active-low request pins enter here
   assign pins = '{
      iack:          iack_i,
      level_sel_hi:  level_sel_hi_i,
      level_sel_lo:  level_sel_lo_i,
      data_strobe_n: data_strobe_n_i,
      video_req_n:   video_req_n_i,
      serial_req_n:  serial_req_n_i,
      pif_req_n:     pif_req_n_i,
      timer_req_n:   timer_req_n_i
   };

   ipa_sync u_sync (
      .sys_clk_i (sys_clk_i),
      .rstn_i    (rstn_i),
      .async_i   (pins),
      .sync_o    (sr)
   );

   // R5: qualified acknowledge cycle and level decode
   assign cycle_on = sr.iack && !sr.data_strobe_n;
   assign sel      = {sr.level_sel_hi, sr.level_sel_lo};
   assign vid_cyc  = cycle_on && (sel == SEL_VIDEO);
   assign lvl5_cyc = cycle_on && (sel == SEL_LEVEL5);
   assign tim_cyc  = cycle_on && (sel == SEL_TIMER);

   // R1: level-2 line covers video, serial, peripheral
   // R3: video 7 (both low), level 5 (bit2), timer 2 (bit1)
   always_ff @(posedge sys_clk_i or negedge rstn_i) begin
      if (!rstn_i) begin
         prio_level_bit2_n_o <= LINE_IDLE;
      end else begin
         prio_level_bit2_n_o <= sr.video_req_n && sr.serial_req_n
                                && sr.pif_req_n;
      end
   end

   // R2: level-1 line for video, or timer alone
   always_ff @(posedge sys_clk_i or negedge rstn_i) begin
      if (!rstn_i) begin
         prio_level_bit1_n_o <= LINE_IDLE;
      end else begin
         prio_level_bit1_n_o <= !(!sr.video_req_n
                                  || (!sr.timer_req_n && sr.serial_req_n
                                      && sr.pif_req_n));
      end
   end

   // R12: every arc below moves at most one output line
   always_comb begin
      next_state = state;
      unique case (state)
         ST_IDLE: begin
            if (vid_cyc) begin
               next_state = ST_VID_ACK;
            end else if (tim_cyc) begin
               next_state = ST_TIM_ACK;
            // R9: serial wins level 5 over peripheral
            end else if (lvl5_cyc && !sr.serial_req_n) begin
               next_state = ST_SER_ACK;
            end else if (lvl5_cyc && !sr.pif_req_n) begin
               next_state = ST_PIF_ACK;
            end
         end
         // R10: hold while cycle persists, unwind one line per step
         ST_TIM_ACK: next_state = tim_cyc ? ST_TIM_VPA : ST_IDLE;
         ST_TIM_VPA: next_state = tim_cyc ? ST_TIM_VPA : ST_TIM_ACK;
         ST_VID_ACK: next_state = vid_cyc ? ST_VID_VPA : ST_IDLE;
         ST_VID_VPA: next_state = vid_cyc ? ST_VID_VPA : ST_VID_ACK;
         ST_SER_ACK: next_state = lvl5_cyc ? ST_SER_DTK : ST_IDLE;
         ST_SER_DTK: next_state = lvl5_cyc ? ST_SER_DTK : ST_SER_ACK;
         ST_PIF_ACK: next_state = lvl5_cyc ? ST_PIF_VPA : ST_IDLE;
         ST_PIF_VPA: next_state = lvl5_cyc ? ST_PIF_VPA : ST_PIF_ACK;
         default:    next_state = ST_IDLE;
      endcase
   end

   always_ff @(posedge sys_clk_i or negedge rstn_i) begin
      if (!rstn_i) begin
         state <= ST_IDLE;
      end else begin
         state <= next_state;
      end
   end

   function automatic ipa_resp_s resp_of(input ipa_state_e s);
      ipa_resp_s r;
      r = RESP_IDLE;
      // R6: autovector after the acknowledge
      unique case (s)
         ST_TIM_ACK: r.timer_ack_n = 1'b0;
         ST_TIM_VPA: begin
            r.timer_ack_n = 1'b0;
            r.vpa_n       = 1'b0;
         end
         ST_VID_ACK: r.video_ack_n = 1'b0;
         ST_VID_VPA: begin
            r.video_ack_n = 1'b0;
            r.vpa_n       = 1'b0;
         end
         // R8: serial acknowledge leads, vector wait
         ST_SER_ACK: r.serial_ack_n = 1'b0;
         // R7: serial completes with transfer acknowledge
         ST_SER_DTK: begin
            r.serial_ack_n = 1'b0;
            r.dtack_n      = 1'b0;
         end
         ST_PIF_ACK: r.pif_ack_n = 1'b0;
         ST_PIF_VPA: begin
            r.pif_ack_n = 1'b0;
            r.vpa_n     = 1'b0;
         end
         default: r = RESP_IDLE;
      endcase
      return r;
   endfunction : resp_of

   // R13: registered from next state, idle high
   // R11: video acknowledge marks both its states, autovector tells them apart
   always_ff @(posedge sys_clk_i or negedge rstn_i) begin
      if (!rstn_i) begin
         resp <= RESP_IDLE;
      end else begin
         resp <= resp_of(next_state);
      end
   end

   assign timer_ack_n_o  = resp.timer_ack_n;
   assign video_ack_n_o  = resp.video_ack_n;
   assign serial_ack_n_o = resp.serial_ack_n;
   assign pif_ack_n_o    = resp.pif_ack_n;
   assign vpa_n_o        = resp.vpa_n;
   assign dtack_n_o      = resp.dtack_n;

   default clocking cb @(posedge sys_clk_i);
   endclocking
   default disable iff (!rstn_i);

   a_level2_any: // R1
      assert property ((!sr.video_req_n || !sr.serial_req_n
                        || !sr.pif_req_n) |=> !prio_level_bit2_n_o)
      else $error("level-2 line not low for pending request");

   a_level1_mix: // R2
      assert property (prio_level_bit1_n_o == !$past(!sr.video_req_n
                       || (!sr.timer_req_n && sr.serial_req_n
                           && sr.pif_req_n)))
      else $error("level-1 line wrong for request mix");

   a_video_seven: // R3
      assert property (!sr.video_req_n |=> (!prio_level_bit1_n_o
                                            && !prio_level_bit2_n_o))
      else $error("video request not at level 7");

   a_ack_needs_cycle: // R5
      assert property ($fell(resp.timer_ack_n) |-> $past(tim_cyc))
      else $error("timer acknowledge without qualified cycle");

   a_autovec_follow: // R6
      assert property ((!resp.timer_ack_n && resp.vpa_n && tim_cyc)
                       |=> !resp.vpa_n)
      else $error("timer acknowledge not followed by autovector");

   a_dtack_serial: // R7
      assert property (!resp.dtack_n |-> (!resp.serial_ack_n
                                          && resp.vpa_n))
      else $error("transfer acknowledge outside serial path");

   a_serial_first: // R8
      assert property ($fell(resp.dtack_n) |-> $past(!resp.serial_ack_n))
      else $error("transfer acknowledge before serial acknowledge");

   a_pif_yields: // R9
      assert property ($fell(resp.pif_ack_n) |-> $past(sr.serial_req_n))
      else $error("peripheral acknowledged while serial pending");

   a_hold_state: // R10
      assert property ((!resp.vpa_n && !resp.video_ack_n && vid_cyc)
                       |=> (!resp.vpa_n && !resp.video_ack_n))
      else $error("video acknowledge dropped while cycle held");

   a_video_mark: // R11
      assert property ($fell(resp.vpa_n) && !resp.video_ack_n
                       |-> $past(!resp.video_ack_n))
      else $error("video autovector without prior marker");

   a_one_change: // R12
      assert property ($countones(resp ^ $past(resp)) <= 1)
      else $error("more than one response line changed");

   a_idle_high: // R13
      assert property ((state == ST_IDLE) |-> (resp == RESP_IDLE))
      else $error("response line low in idle");

   a_level2_clear: // R1
      assert property ((sr.video_req_n && sr.serial_req_n && sr.pif_req_n)
                       |=> prio_level_bit2_n_o)
      else $error("level-2 line low with no pending request");

   a_level5_mid: // R3
      assert property ((sr.video_req_n
                        && (!sr.serial_req_n || !sr.pif_req_n))
                       |=> (!prio_level_bit2_n_o && prio_level_bit1_n_o))
      else $error("level-5 request not at level 5");

   a_timer_two: // R3
      assert property ((!sr.timer_req_n && sr.video_req_n
                        && sr.serial_req_n && sr.pif_req_n)
                       |=> (prio_level_bit2_n_o && !prio_level_bit1_n_o))
      else $error("timer request not at level 2");

   a_one_ack: // R4
      assert property ($countones(~{resp.timer_ack_n, resp.video_ack_n,
                                    resp.serial_ack_n, resp.pif_ack_n}) <= 1)
      else $error("more than one acknowledge line low");

   a_idle_no_cycle: // R5
      assert property (((state == ST_IDLE) && !cycle_on)
                       |=> (resp == RESP_IDLE))
      else $error("acknowledge outside qualified cycle");

   a_vpa_after_ack: // R6
      assert property ($fell(resp.vpa_n) |-> $past(!resp.timer_ack_n
                       || !resp.video_ack_n || !resp.pif_ack_n))
      else $error("autovector without a prior acknowledge");

   a_pif_autovec: // R6
      assert property ((!resp.pif_ack_n && resp.vpa_n && lvl5_cyc)
                       |=> !resp.vpa_n)
      else $error("peripheral acknowledge not followed by autovector");

   a_serial_no_vpa: // R7
      assert property (!resp.serial_ack_n |-> resp.vpa_n)
      else $error("autovector given on serial acknowledge");

   a_dtack_follow: // R8
      assert property ((!resp.serial_ack_n && resp.dtack_n && lvl5_cyc)
                       |=> !resp.dtack_n)
      else $error("serial acknowledge not followed by transfer acknowledge");

   a_vector_wait: // R8
      assert property ($fell(resp.serial_ack_n) |-> resp.dtack_n)
      else $error("transfer acknowledge without vector wait");

   a_serial_needs_req: // R9
      assert property ($fell(resp.serial_ack_n)
                       |-> $past(!sr.serial_req_n && lvl5_cyc))
      else $error("serial acknowledged without its request");

   a_dtack_hold: // R10
      assert property ((!resp.dtack_n && lvl5_cyc) |=> !resp.dtack_n)
      else $error("transfer acknowledge dropped while cycle held");

   a_release_order: // R12
      assert property ($rose(resp.vpa_n) |-> !(resp.timer_ack_n
                       && resp.video_ack_n && resp.pif_ack_n))
      else $error("acknowledge released together with autovector");

   c_video_ack:
      cover property (!resp.video_ack_n && !resp.vpa_n);
   c_serial_dtack:
      cover property (!resp.serial_ack_n && !resp.dtack_n);
   c_pif_ack:
      cover property (!resp.pif_ack_n && !resp.vpa_n);
   c_timer_ack:
      cover property (!resp.timer_ack_n ##1 !resp.vpa_n);
   c_serial_wins:
      cover property (!resp.serial_ack_n && !sr.pif_req_n);

endmodule : ipa_seq_top

// File: verification/ipa_periph_model.sv
`timescale 1ns/100ps
module ipa_periph_model (
   input  wire logic       sys_clk_i,
   input  wire logic       rstn_i,
   input  wire logic [3:0] want_i,
   input  wire logic [3:0] ack_n_i,
   output logic      [3:0] req_n_o
);
   logic [3:0] served;
   always_ff @(posedge sys_clk_i or negedge rstn_i) begin
      if (!rstn_i) begin
         served <= 4'h0;
      end else begin
         served <= want_i & (served | ~ack_n_i);
      end
   end
   assign req_n_o = ~want_i | served;
endmodule : ipa_periph_model

// File: verification/ipa_seq_top_tb_top.sv
`timescale 1ns/100ps
module ipa_seq_top_tb_top;
   import ipa_pkg::*;
   logic       clk  = 1'b0;
   logic       rstn = 1'b0;
   logic       iack = 1'b0;
   logic       hi   = 1'b0;
   logic       lo   = 1'b0;
   logic       ds_n = 1'b1;
   logic [3:0] want = 4'h0;
   logic [3:0] req_n;
   logic       b1;
   logic       b2;
   ipa_resp_s  resp;
   int         errors     = 0;
   int         num_checks = 0;
   // want bits: video, serial, peripheral, timer; then bit2, bit1
   logic [5:0] rows [7] = '{6'h03, 6'h20, 6'h11, 6'h09, 6'h06, 6'h15, 6'h24};

   always #5 clk = ~clk;

   ipa_periph_model peer_u (
      .sys_clk_i (clk),
      .rstn_i    (rstn),
      .want_i    (want),
      .ack_n_i   ({resp.video_ack_n, resp.serial_ack_n,
                   resp.pif_ack_n, resp.timer_ack_n}),
      .req_n_o   (req_n)
   );

   ipa_seq_top dut_u (
      .sys_clk_i           (clk),
      .rstn_i              (rstn),
      .iack_i              (iack),
      .level_sel_hi_i      (hi),
      .level_sel_lo_i      (lo),
      .data_strobe_n_i     (ds_n),
      .video_req_n_i       (req_n[3]),
      .serial_req_n_i      (req_n[2]),
      .pif_req_n_i         (req_n[1]),
      .timer_req_n_i       (req_n[0]),
      .prio_level_bit1_n_o (b1),
      .prio_level_bit2_n_o (b2),
      .timer_ack_n_o       (resp.timer_ack_n),
      .video_ack_n_o       (resp.video_ack_n),
      .serial_ack_n_o      (resp.serial_ack_n),
      .pif_ack_n_o         (resp.pif_ack_n),
      .vpa_n_o             (resp.vpa_n),
      .dtack_n_o           (resp.dtack_n)
   );

   task go(input int n);
      repeat (n) @(negedge clk);
   endtask : go

   task chk_prio(input logic [1:0] exp);
      num_checks++;
      if ({b2, b1} !== exp) begin
         errors++;
         $display("[ERR] prio exp %b seen %b", exp, {b2, b1});
      end
   endtask : chk_prio

   task chk_resp(input ipa_resp_s exp);
      num_checks++;
      if (resp !== exp) begin
         errors++;
         $display("[ERR] resp exp %b seen %b", exp, resp);
      end
   endtask : chk_resp

   task complete_run;
      $display("checks %0d errors %0d", num_checks, errors);
      if (errors == 0 && num_checks > 0) begin
         $display("ALL CHECKS OK");
      end else begin
         $display("CHECKS NOT OK");
      end
      $finish;
   endtask : complete_run

   // acknowledge cycle: enter, hold, release by strobe
   task acyc(input logic ia, input logic [1:0] sel, input logic [3:0] w,
             input ipa_resp_s exp);
      ipa_resp_s ack_only;
      ack_only = exp;
      ack_only.vpa_n = 1'b1;
      ack_only.dtack_n = 1'b1;
      want = w;
      go(4);
      iack = ia;
      {hi, lo} = sel;
      ds_n = 1'b0;
      go(3);
      chk_resp(ack_only);
      go(1);
      chk_resp(exp);
      go(6);
      chk_resp(exp);
      ds_n = 1'b1;
      go(3);
      chk_resp(ack_only);
      go(1);
      chk_resp(RESP_IDLE);
      iack = 1'b0;
      want = 4'h0;
   endtask : acyc

   initial begin
      #20000;
      errors++;
      complete_run();
   end

   initial begin
      go(12);
      chk_resp(RESP_IDLE);
      rstn = 1'b1;
      go(2);
      for (int i = 0; i < 7; i++) begin
         want = rows[i][5:2];
         go(4);
         chk_prio(rows[i][1:0]);
      end
      acyc(1'b1, 2'h3, 4'h8, ipa_resp_s'(6'h2D));
      acyc(1'b1, 2'h1, 4'h1, ipa_resp_s'(6'h1D));
      acyc(1'b1, 2'h2, 4'h6, ipa_resp_s'(6'h36));
      acyc(1'b1, 2'h2, 4'h2, ipa_resp_s'(6'h39));
      acyc(1'b1, 2'h0, 4'hF, RESP_IDLE);
      acyc(1'b1, 2'h2, 4'h1, RESP_IDLE);
      acyc(1'b0, 2'h3, 4'h8, RESP_IDLE);
      go(1);
      // strobe blip during unwind re-asserts the autovector
      want = 4'h8;
      iack = 1'b1;
      {hi, lo} = 2'h3;
      ds_n = 1'b0;
      go(4);
      chk_resp(ipa_resp_s'(6'h2D));
      ds_n = 1'b1;
      go(1);
      ds_n = 1'b0;
      go(2);
      chk_resp(ipa_resp_s'(6'h2F));
      go(1);
      chk_resp(ipa_resp_s'(6'h2D));
      // reset in mid-cycle
      want = 4'h8;
      iack = 1'b1;
      {hi, lo} = 2'h3;
      ds_n = 1'b0;
      go(9);
      rstn = 1'b0;
      go(1);
      chk_resp(RESP_IDLE);
      chk_prio(2'h3);
      iack = 1'b0;
      ds_n = 1'b1;
      go(2);
      rstn = 1'b1;
      go(4);
      chk_prio(2'h0);
      chk_resp(RESP_IDLE);
      complete_run();
   end
endmodule : ipa_seq_top_tb_top
